/* File: rtl/rsd_consts.svh */
/*
 Constants of the repeater status display and host nibble port.
 Assumes a 100 MHz aclk; included by the top module and the testbench.
*/
// Summary of operation
// - Display update drives slot address on bus bits 7:5.
// - Slot 0 shows any collision, any reception, lockout, any isolated.
// - Slots 1-7 show link, collision, reception, isolation per port.
// - Polarity on bit 4 and link on bit 0 only for ports 2-7.
// - Polarity bit is meaningful only with the internal transceiver.
// - Pulse the latch strobe once per presented slot.
// - Pulse the packet freeze strobe high at each packet end.
// - Freeze display until next packet starts or 30 ms pass.
// - Nibble bus: 4-bit address and 4-bit data on shared pins.
// - During display updates the device drives address and data lines.
// - 8-bit registers, accessed by nibble, bit 7 picks upper or lower; writes act only with bit 7 low and set upper nibble bit 0.
// - Finish current slot, then assert buffer enable low.
// - On write the device turns its data drivers off.
// - Configuration load picks one of four external transceiver groupings.
// - Port 1 always uses the attachment unit interface.
// - Link check off bit stops link pulses and link fail.
// - Internal transceivers detect and correct receive polarity.
// - Polarity correction disabled when configuration selects it.
// - After load rises, one second LED test, no repetition.
`ifndef RSD_CONSTS_SVH
`define RSD_CONSTS_SVH
`define RSD_CLK_HZ 100000000
`define RSD_FREEZE_MS 30
`define RSD_TEST_S 1
`define RSD_ADDR_CTRL 4'h0
`define RSD_ADDR_STAT 4'h4
`define RSD_EXT_ALL 7'h7E
`define RSD_EXT_23 7'h06
`define RSD_EXT_25 7'h1E
`define RSD_EXT_NONE 7'h00
`define RSD_RESP_OK 2'h0
`define RSD_RESP_ERR 2'h2
`endif

/* File: rtl/rsd_pkg.sv */
/*
 Types of the repeater status display block.
 Assumes rsd_consts.svh is on the include path.
*/
package rsd_pkg;
   typedef enum logic [2:0] {
      ST_SHOW, ST_STROBE, ST_NEXT, ST_ACCESS
   } rsd_state_t;
   typedef struct packed {
      logic [2:0] slot;
      logic [4:0] bits;
   } rsd_word_t;
   typedef struct packed {
      logic [6:0] col;
      logic [6:0] rx;
      logic [6:0] iso;
      logic [6:0] link;
      logic [6:0] pol;
   } rsd_port_t;
endpackage

/* File: rtl/rsd_top.sv */
/*
 Status display, nibble host port and port option logic of a repeater.
 Assumes port status from same-clock logic; pins are synchronised here.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rsd_consts.svh"
module rsd_top
   import rsd_pkg::*;
#(
   parameter int FREEZE_CYC = `RSD_FREEZE_MS * (`RSD_CLK_HZ / 1000),
   parameter int TEST_CYC = `RSD_TEST_S * `RSD_CLK_HZ
)(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [3:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   input wire logic config_load_n,
   input wire logic [1:0] ext_xcvr_select,
   input wire logic pol_fix_off,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [7:0] d_i,
   output logic [7:0] d_o,
   output logic [7:0] d_oe,
   output logic bus_buffer_enable_n,
   output logic display_latch_pulse,
   output logic packet_freeze_pulse,
   input wire rsd_port_t port_st,
   input wire logic babble_lockout_flag,
   input wire logic pkt_end,
   input wire logic pkt_start,
   output logic [6:0] port_ext_xcvr,
   output logic [6:0] link_pulse_en,
   output logic [6:0] pol_fix_en,
   output logic repeat_inhibit
);
   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [1:0] ld_s, rd_s, wr_s;
   logic [7:0] di_m, di_q;
   logic [2:0] xc_m, xc_q;
   always_ff @(posedge aclk)
   begin
      ld_s <= {ld_s[0], config_load_n};
      rd_s <= {rd_s[0], rd_n};
      wr_s <= {wr_s[0], wr_n};
      di_m <= d_i;
      di_q <= di_m;
      xc_m <= {pol_fix_off, ext_xcvr_select};
      xc_q <= xc_m;
   end
   // Load low holds all but the configuration capture in reset, as the pin is the chip reset
   logic rst, ld_prev_q;
   assign rst = !aresetn || !ld_s[1];
   ////////////////////////////////////////////////////////////////////
   // Configuration capture and LED test
   logic [1:0] xsel_q;
   logic pfo_q;
   logic [31:0] test_cnt_q;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         // Idle level of the load pin, so a plain reset sees no false rise
         ld_prev_q <= 1'b1;
         xsel_q <= 2'h0;
         pfo_q <= 1'b0;
      end
      else
      begin
         ld_prev_q <= ld_s[1];
         if (ld_s[1] && !ld_prev_q)
         begin
            xsel_q <= xc_q[1:0];
            pfo_q <= xc_q[2];
         end
      end
   end
   always_ff @(posedge aclk)
   begin
      if (rst)
      begin
         test_cnt_q <= 32'h0;
         repeat_inhibit <= 1'b1;
      end
      else if (repeat_inhibit)
      begin
         test_cnt_q <= test_cnt_q + 32'h1;
         // Repetition stays blocked for the whole
         if (test_cnt_q == 32'(TEST_CYC - 1))
            repeat_inhibit <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Port options
   logic [6:0] ext_mask, lco_q;
   always_comb
   begin
      case (xsel_q)
         2'h0: ext_mask = `RSD_EXT_ALL;
         2'h1: ext_mask = `RSD_EXT_23;
         2'h2: ext_mask = `RSD_EXT_25;
         default: ext_mask = `RSD_EXT_NONE;
      endcase
   end
   always_ff @(posedge aclk)
   begin
      if (rst)
      begin
         port_ext_xcvr <= 7'h00;
         link_pulse_en <= 7'h00;
         pol_fix_en <= 7'h00;
      end
      else
      begin
         // Bit 0 is the AUI port and never has a transceiver
         port_ext_xcvr <= ext_mask;
         link_pulse_en <= ~lco_q & ~ext_mask & 7'h7E;
         pol_fix_en <= pfo_q ? 7'h00 : ~ext_mask & 7'h7E;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Status gathering; link check off forces link good
   logic [6:0] link_eff;
   logic [4:0] sb [8];
   assign link_eff = (port_st.link | lco_q) & 7'h7E;
   assign sb[0] = {1'b0, |port_st.iso, babble_lockout_flag,
                   |port_st.rx, |port_st.col};
   genvar gi;
   generate
      for (gi = 1; gi < 8; gi++)
      begin : g_slot
         // Port 1 carries neither link nor polarity
         // Polarity reads zero unless the internal transceiver is used
         assign sb[gi] = {port_st.pol[gi-1] & ~ext_mask[gi-1] & (gi > 1),
                          port_st.iso[gi-1], port_st.rx[gi-1],
                          port_st.col[gi-1], link_eff[gi-1] & (gi > 1)};
      end
   endgenerate
   ////////////////////////////////////////////////////////////////////
   // Freeze after packet end
   logic frz_q;
   logic [31:0] frz_cnt_q;
   logic [4:0] snap_q [8];
   always_ff @(posedge aclk)
   begin
      if (rst)
      begin
         frz_q <= 1'b0;
         frz_cnt_q <= 32'h0;
         packet_freeze_pulse <= 1'b0;
      end
      else
      begin
         packet_freeze_pulse <= pkt_end;
         // A new end wins over a start in the same cycle
         if (pkt_end)
         begin
            frz_q <= 1'b1;
            frz_cnt_q <= 32'h0;
         end
         else if (frz_q)
         begin
            frz_cnt_q <= frz_cnt_q + 32'h1;
            if (pkt_start || frz_cnt_q == 32'(FREEZE_CYC - 1))
               frz_q <= 1'b0;
         end
      end
   end
   always_ff @(posedge aclk)
   begin
      for (int i = 0; i < 8; i++)
         if (!frz_q || pkt_end)
            snap_q[i] <= sb[i];
   end
   ////////////////////////////////////////////////////////////////////
   // Display and host access sequencer
   rsd_state_t st_q;
   logic [2:0] slot_q;
   logic acc_req, is_wr_q;
   logic [7:0] wdat_q;
   logic [7:0] nib_lo [8];
   rsd_word_t shown;
   assign acc_req = !rd_s[1] || !wr_s[1];
   assign shown.slot = slot_q;
   assign shown.bits = repeat_inhibit ? 5'h1F : snap_q[slot_q];
   always_ff @(posedge aclk)
   begin
      if (rst)
      begin
         st_q <= ST_SHOW;
         slot_q <= 3'h0;
         is_wr_q <= 1'b0;
         wdat_q <= 8'h00;
         d_o <= 8'h00;
         d_oe <= 8'h00;
         bus_buffer_enable_n <= 1'b1;
         display_latch_pulse <= 1'b0;
      end
      else
      begin
         display_latch_pulse <= 1'b0;
         case (st_q)
            ST_SHOW:
            begin
               d_o <= shown;
               d_oe <= 8'hFF;
               st_q <= ST_STROBE;
            end
            ST_STROBE:
            begin
               display_latch_pulse <= 1'b1;
               st_q <= ST_NEXT;
            end
            ST_NEXT:
            begin
               slot_q <= slot_q + 3'h1;
               // A slot already begun is always completed first
               if (acc_req)
               begin
                  st_q <= ST_ACCESS;
                  is_wr_q <= !wr_s[1];
                  bus_buffer_enable_n <= 1'b0;
                  d_oe <= 8'h00;
               end
               else
                  st_q <= ST_SHOW;
            end
            ST_ACCESS:
            begin
               if (!acc_req)
               begin
                  bus_buffer_enable_n <= 1'b1;
                  st_q <= ST_SHOW;
                  d_oe <= 8'h00;
               end
               else if (is_wr_q)
               begin
                  wdat_q <= di_q;
                  d_oe <= 8'h00;
               end
               else
               begin
                  // Address in on 7:4, nibble out on 3:0
                  d_o <= {4'h0, di_q[7] ? nib_lo[di_q[6:4]][7:4]
                                         : nib_lo[di_q[6:4]][3:0]};
                  d_oe <= 8'h0F;
               end
            end
            default: st_q <= ST_SHOW;
         endcase
      end
   end
   // Register images: upper nibble bit 0 reports link check off
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_reg
         if (gi == 0)
            assign nib_lo[gi] = {4'h0, sb[0][3:0]};
         else
            assign nib_lo[gi] = {3'h0, lco_q[gi-1], sb[gi][3:0]};
      end
   endgenerate
   logic wr_done;
   assign wr_done = st_q == ST_ACCESS && is_wr_q && !acc_req;
   ////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave
   logic [3:0] rd_addr;
   always_ff @(posedge aclk)
   begin
      if (rst)
      begin
         s_awready <= 1'b0;
         s_wready <= 1'b0;
         s_bvalid <= 1'b0;
         s_bresp <= `RSD_RESP_OK;
         lco_q <= 7'h00;
      end
      else
      begin
         s_awready <= 1'b0;
         s_wready <= 1'b0;
         if (s_bvalid && s_bready)
            s_bvalid <= 1'b0;
         if (s_awvalid && s_wvalid && !s_bvalid && !s_awready)
         begin
            s_awready <= 1'b1;
            s_wready <= 1'b1;
            s_bvalid <= 1'b1;
            s_bresp <= `RSD_RESP_ERR;
            if (s_awaddr == `RSD_ADDR_CTRL)
            begin
               s_bresp <= `RSD_RESP_OK;
               if (s_wstrb[0])
                  lco_q <= s_wdata[6:0];
            end
         end
         else if (wr_done && !wdat_q[7] && wdat_q[6:4] != 3'h0)
            lco_q[wdat_q[6:4] - 3'h1] <= wdat_q[0];
      end
   end
   assign rd_addr = s_araddr;
   always_ff @(posedge aclk)
   begin
      if (rst)
      begin
         s_arready <= 1'b0;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0;
         s_rresp <= `RSD_RESP_OK;
      end
      else
      begin
         s_arready <= 1'b0;
         if (s_rvalid && s_rready)
            s_rvalid <= 1'b0;
         if (s_arvalid && !s_rvalid && !s_arready)
         begin
            s_arready <= 1'b1;
            s_rvalid <= 1'b1;
            s_rresp <= `RSD_RESP_OK;
            if (rd_addr == `RSD_ADDR_CTRL)
               s_rdata <= {25'h0, lco_q};
            else if (rd_addr == `RSD_ADDR_STAT)
               s_rdata <= {23'h0, pfo_q, xsel_q, repeat_inhibit,
                           frz_q, !bus_buffer_enable_n, slot_q};
            else
            begin
               s_rdata <= 32'h0;
               s_rresp <= `RSD_RESP_ERR;
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Checks
   property p_strobe_slot;
      @(posedge aclk) disable iff (rst)
      display_latch_pulse |-> d_oe == 8'hFF && d_o[7:5] == slot_q;
   endproperty
   a_strobe_slot: assert property (p_strobe_slot)
      else $error("strobe without driven slot");
   property p_strobe_once;
      @(posedge aclk) disable iff (rst)
      display_latch_pulse |=> !display_latch_pulse;
   endproperty
   a_strobe_once: assert property (p_strobe_once)
      else $error("latch strobe longer than one cycle");
   property p_freeze_pulse;
      @(posedge aclk) disable iff (rst)
      pkt_end |=> packet_freeze_pulse && frz_q;
   endproperty
   a_freeze_pulse: assert property (p_freeze_pulse)
      else $error("no freeze strobe after packet end");
   property p_unfreeze;
      @(posedge aclk) disable iff (rst)
      frz_q && pkt_start && !pkt_end |=> !frz_q;
   endproperty
   a_unfreeze: assert property (p_unfreeze)
      else $error("freeze not ended by packet start");
   property p_no_drive_wr;
      @(posedge aclk) disable iff (rst)
      st_q == ST_ACCESS && is_wr_q |-> d_oe == 8'h00;
   endproperty
   a_no_drive_wr: assert property (p_no_drive_wr)
      else $error("drivers on during host write");
   property p_buf_en;
      @(posedge aclk) disable iff (rst)
      st_q == ST_NEXT && acc_req |=> !bus_buffer_enable_n;
   endproperty
   a_buf_en: assert property (p_buf_en)
      else $error("buffer enable not asserted");
   property p_aui;
      @(posedge aclk) disable iff (rst)
      !port_ext_xcvr[0] && !link_pulse_en[0] && !pol_fix_en[0];
   endproperty
   a_aui: assert property (p_aui)
      else $error("port 1 given a transceiver option");
   property p_lco;
      @(posedge aclk) disable iff (rst)
      ##1 lco_q[1] && !$past(rst) |=> !link_pulse_en[1];
   endproperty
   a_lco: assert property (p_lco)
      else $error("link pulses on with check off");
   property p_polfix;
      @(posedge aclk) disable iff (rst)
      pfo_q && $stable(pfo_q) |=> pol_fix_en == 7'h00;
   endproperty
   a_polfix: assert property (p_polfix)
      else $error("polarity fix enabled when disabled");
   property p_test;
      @(posedge aclk) disable iff (rst)
      repeat_inhibit && st_q == ST_SHOW |=> d_o[4:0] == 5'h1F;
   endproperty
   a_test: assert property (p_test)
      else $error("LED test not all on");
   c_write: cover property (@(posedge aclk) disable iff (rst) wr_done);
   c_read: cover property (@(posedge aclk) disable iff (rst)
      st_q == ST_ACCESS && !is_wr_q && d_oe == 8'h0F);
   c_wrap: cover property (@(posedge aclk) disable iff (rst)
      display_latch_pulse && slot_q == 3'h7);
   c_frz: cover property (@(posedge aclk) disable iff (rst)
      frz_q ##1 !frz_q);
endmodule // rsd_top
`default_nettype wire

/* File: sim/rsd_led_latch.sv */
/*
 Model of the LED addressable latches on the status display bus.
 Assumes d_o, d_oe and the latch strobe come from rsd_top on aclk.
*/
`timescale 1ns/100ps
`default_nettype none
module rsd_led_latch
   import rsd_pkg::*;
(
   input wire logic aclk,
   input wire logic [7:0] d_o,
   input wire logic [7:0] d_oe,
   input wire logic display_latch_pulse,
   output var logic [7:0][4:0] leds,
   output var int oe_bad
);
   initial oe_bad = 0;
   ////////////////////////////////////////////////////////////////////
   // Slot address on the top lines picks the latch entry that loads the five low bits
   always @(posedge aclk)
   begin
      if (display_latch_pulse === 1'b1)
      begin
         leds[d_o[7:5]] <= d_o[4:0];
         if (d_oe !== 8'hFF)
            oe_bad <= oe_bad + 1;
      end
   end
endmodule // rsd_led_latch
`default_nettype wire

/* File: sim/rsd_top_tb_top.sv */
/*
 Self-checking bench of rsd_top with the LED latch model.
 Assumes the rtl package and header are compiled and on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rsd_consts.svh"
module rsd_top_tb_top
   import rsd_pkg::*;
;
   // Short counts keep the run brief; expectations follow these values
   localparam int FRZ = 50;
   localparam int TST = 40;
   logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [3:0] s_awaddr, s_araddr, s_wstrb, v;
   logic [31:0] s_wdata, s_rdata, seed, q, d;
   logic [1:0] s_bresp, s_rresp, xsel, r;
   logic cfg_n, pfo, rd_n, wr_n, lock, pend, pstart, bben_n, dlp, pfp, rinh;
   logic [7:0] d_i, d_o, d_oe, host_d;
   logic [6:0] pext, lpe, pfe, lco;
   logic [7:0][4:0] leds, snap;
   logic [63:0] r64;
   rsd_port_t pst;
   int oe_bad, fails, num_checks, n;
   always #5 aclk = ~aclk;
   // Wire level of the shared bus: device bits where d_oe is set, host bits elsewhere
   assign d_i = (d_oe & d_o) | (~d_oe & host_d);
   rsd_top #(.FREEZE_CYC(FRZ), .TEST_CYC(TST)) u_rsd_top (
      .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
      .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
      .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
      .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
      .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
      .s_rready(s_rready), .config_load_n(cfg_n), .ext_xcvr_select(xsel),
      .pol_fix_off(pfo), .rd_n(rd_n), .wr_n(wr_n), .d_i(d_i), .d_o(d_o),
      .d_oe(d_oe), .bus_buffer_enable_n(bben_n),
      .display_latch_pulse(dlp), .packet_freeze_pulse(pfp), .port_st(pst),
      .babble_lockout_flag(lock), .pkt_end(pend), .pkt_start(pstart),
      .port_ext_xcvr(pext), .link_pulse_en(lpe), .pol_fix_en(pfe),
      .repeat_inhibit(rinh));
   rsd_led_latch u_rsd_led_latch (.aclk(aclk), .d_o(d_o), .d_oe(d_oe),
      .display_latch_pulse(dlp), .leds(leds), .oe_bad(oe_bad));
   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [6:0] exp_ext(input logic [1:0] s);
      case (s)
         2'h0: return `RSD_EXT_ALL;
         2'h1: return `RSD_EXT_23;
         2'h2: return `RSD_EXT_25;
         default: return `RSD_EXT_NONE;
      endcase
   endfunction
   function automatic logic [4:0] exp_slot(input int k, input rsd_port_t p,
      input logic [6:0] c, input logic lk, input logic [6:0] e);
      if (k == 0)
         return {1'b0, |p.iso, lk, |p.rx, |p.col};
      return {p.pol[k-1] & ~e[k-1] & (k > 1), p.iso[k-1], p.rx[k-1],
         p.col[k-1], (p.link[k-1] | c[k-1]) & (k > 1)};
   endfunction
   ////////////////////////////////////////////////////////////////////
   task print_verdict();
      if (fails == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task tmo();
      fails++;
      print_verdict();
   endtask
   task chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task step(input int k);
      repeat (k) @(posedge aclk);
   endtask
   task axi_wr(input logic [3:0] a, input logic [31:0] dat);
      @(posedge aclk);
      s_awaddr <= a;
      s_wdata <= dat;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      for (n = 0; n < 50 && s_bvalid !== 1'b1; n++)
      begin
         @(posedge aclk);
         if (s_awready === 1'b1)
            s_awvalid <= 1'b0;
         if (s_wready === 1'b1)
            s_wvalid <= 1'b0;
      end
      r = s_bresp;
      s_bready <= 1'b0;
      if (n == 50)
         tmo();
   endtask
   task axi_rd(input logic [3:0] a);
      @(posedge aclk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      for (n = 0; n < 50 && s_rvalid !== 1'b1; n++)
      begin
         @(posedge aclk);
         if (s_arready === 1'b1)
            s_arvalid <= 1'b0;
      end
      d = s_rdata;
      r = s_rresp;
      s_rready <= 1'b0;
      if (n == 50)
         tmo();
   endtask
   // Host cycle: strobe low until the buffer enable answers, six cycles more, then released until it clears
   task nib(input logic w, input logic [7:0] a);
      @(posedge aclk);
      host_d <= a;
      rd_n <= w;
      wr_n <= ~w;
      for (n = 0; n < 60 && bben_n !== 1'b0; n++)
         @(posedge aclk);
      if (n == 60)
         tmo();
      step(6);
      v = d_o[3:0];
      chk(d_oe, w ? 8'h00 : 8'h0F);
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      for (n = 0; n < 60 && bben_n !== 1'b1; n++)
         @(posedge aclk);
      if (n == 60)
         tmo();
   endtask
   task load(input logic [1:0] s, input logic p);
      @(posedge aclk);
      cfg_n <= 1'b0;
      xsel <= s;
      pfo <= p;
      step(4);
      chk(rinh, 1'b1);
      cfg_n <= 1'b1;
      lco = 7'h00;
      step(36);
      chk(rinh, 1'b1);
      chk(leds, {8{5'h1F}});
      step(24);
      chk(rinh, 1'b0);
   endtask
   task pulse_end();
      @(posedge aclk);
      pend <= 1'b1;
      @(posedge aclk);
      pend <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      {aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid} = '0;
      {s_rready, pfo, lock, pend, pstart, xsel, s_awaddr, s_araddr} = '0;
      {cfg_n, rd_n, wr_n, s_wstrb, s_wdata, host_d} = {3'b111, 4'hF, 40'h0};
      pst = '0;
      seed = 32'h0000002B;
      fails = 0;
      num_checks = 0;
      step(12);
      aresetn <= 1'b1;
      for (int s = 0; s < 4; s++)
      begin
         load(s[1:0], s[0]);
         chk(pext, exp_ext(s[1:0]));
         chk(pfe, s[0] ? 7'h00 : 7'h7E & ~exp_ext(s[1:0]));
         q = rnd();
         axi_wr(4'h0, q);
         chk(r, `RSD_RESP_OK);
         lco = q[6:0];
         axi_rd(4'h0);
         chk(d, {25'h0, lco});
         chk(lpe, 7'h7E & ~exp_ext(s[1:0]) & ~lco);
         axi_rd(4'h4);
         chk(d[8:4], {s[0], s[1:0], 2'b00});
         r64 = {rnd(), rnd()};
         pst <= r64[34:0];
         lock <= r64[40];
         step(30);
         for (int k = 0; k < 8; k++)
            chk(leds[k], exp_slot(k, pst, lco, lock, exp_ext(s[1:0])));
      end
      axi_wr(4'h8, 32'h0000007F);
      chk(r, `RSD_RESP_ERR);
      axi_rd(4'hC);
      chk({d, 30'h0, r}, {32'h0, 30'h0, `RSD_RESP_ERR});
      pulse_end();
      #1 chk(pfp, 1'b1);
      @(posedge aclk);
      #1 chk(pfp, 1'b0);
      snap = leds;
      r64 = {rnd(), rnd()};
      pst <= r64[34:0];
      step(30);
      chk(leds, snap);
      axi_rd(4'h4);
      chk(d[4], 1'b1);
      step(FRZ);
      axi_rd(4'h4);
      chk(d[4], 1'b0);
      pulse_end();
      pstart <= 1'b1;
      @(posedge aclk);
      pstart <= 1'b0;
      axi_rd(4'h4);
      chk(d[4], 1'b0);
      nib(1'b0, 8'hB0);
      chk(v[0], lco[2]);
      nib(1'b1, 8'h41);
      lco[3] = 1'b1;
      nib(1'b1, 8'h01);
      axi_rd(4'h0);
      chk(d, {25'h0, lco});
      chk(oe_bad, 0);
      print_verdict();
   end
endmodule // rsd_top_tb_top
`default_nettype wire
